// ---- design/scr_pkg.sv ----
package scr_pkg;

  // ==========================================================================
  // register map (byte addresses, compared directly with the bus address)
  localparam logic [3:0] ADDR_W              = 4'h4;
  localparam logic [3:0] OFS_SYSTEM_OPTIONS  = 4'h0;
  localparam logic [3:0] OFS_PART_HIGH       = 4'h4;
  localparam logic [3:0] OFS_PART_LOW        = 4'h8;
  localparam logic [3:0] OFS_WAKEUP_CTRL     = 4'hC;
  // low-voltage control sits at 0x10, beyond a 4-bit address: use 5-bit bus
  localparam int         BUS_AW              = 5;
  localparam logic [4:0] OFS_LOW_VOLTAGE     = 5'h10;

  // ==========================================================================
  // system options fields
  localparam int BIT_WDOG_CLK   = 7;
  localparam int BIT_TWO_WIRE   = 1;
  localparam int BIT_CMP_CAP    = 0;

  // wakeup control fields
  localparam int BIT_WAKE_FLAG  = 7;
  localparam int BIT_WAKE_ACK   = 6;
  localparam int BIT_WAKE_CLK   = 5;
  localparam int BIT_WAKE_IE    = 4;

  // low-voltage control fields
  localparam int BIT_LV_FLAG    = 7;
  localparam int BIT_LV_ACK     = 6;
  localparam int BIT_LV_IE      = 5;
  localparam int BIT_LV_RE      = 4;
  localparam int BIT_LV_SE      = 3;
  localparam int BIT_LV_DE      = 2;
  localparam int BIT_REF_BUF    = 0;

  // ==========================================================================
  // reset values
  localparam logic [7:0] RST_SYSTEM_OPTIONS = 8'h00;
  localparam logic [7:0] RST_WAKEUP_CTRL    = 8'h00;
  localparam logic [7:0] RST_LOW_VOLTAGE    = 8'h00;

  // part number; value arbitrary
  localparam logic [11:0] PART_NUMBER       = 12'h5A3;

  // ==========================================================================
  // timing: 1 kHz tick derived from the 25 MHz clock
  localparam int CLK_HZ          = 25000000;
  localparam int TICK_HZ         = 1000;
  localparam int TICK_CYCLES     = CLK_HZ / TICK_HZ;
  localparam logic [14:0] TICK_LAST = 15'(TICK_CYCLES - 1);

  // internal-clock timeouts in milliseconds (ticks of the 1 kHz clock)
  localparam int WAKE_MS_1 = 8;
  localparam int WAKE_MS_2 = 32;
  localparam int WAKE_MS_3 = 64;
  localparam int WAKE_MS_4 = 128;
  localparam int WAKE_MS_5 = 256;
  localparam int WAKE_MS_6 = 512;
  localparam int WAKE_MS_7 = 1024;

  // external-clock timeouts in external periods
  localparam int WAKE_EXT_1 = 256;
  localparam int WAKE_EXT_2 = 1024;
  localparam int WAKE_EXT_3 = 2048;
  localparam int WAKE_EXT_4 = 4096;
  localparam int WAKE_EXT_5 = 8192;
  localparam int WAKE_EXT_6 = 16384;
  localparam int WAKE_EXT_7 = 32768;

endpackage

// ---- design/scr_system_control.sv ----
// Functional notes
// - options bit 7 picks watchdog clock: 1 internal 1 kHz, 0 bus clock.
// - write-once bits accept only the first write after reset.
// - options bit 1 routes two-wire pins: 0 port A 2/3, 1 port B 6/7.
// - options bit 0 connects comparator output to timer capture channel 0.
// - part number high bits 7:4 read indeterminate, writes ignored.
// - fixed 12-bit part number split across high nibble and low byte.
// - wakeup flag bit 7 sets when wakeup timer reaches its timeout.
// - writing 1 to wakeup bit 6 clears the flag; reads zero.
// - wakeup bit 5 selects clock: 0 internal 1 kHz, 1 external.
// - wakeup bit 4 enables wakeup interrupt requests.
// - wakeup bits 2:0 select period; zero disables the timer.
// - internal periods 8,32,64,128,256,512 ms and 1.024 s.
// - external periods 256 to 32768 external clock periods.
// - first timeout may be short by up to one 1 kHz period.
// - low-voltage flag bit 7 sets on detect event while enabled.
// - writing 1 to low-voltage bit 6 clears flag; reads zero.
// - low-voltage bit 5 enables interrupt while flag set.
// - write-once bit 4 forces reset on flag when detection enabled.
// - bit 3 keeps detection in stop mode, only when enabled.
// - write-once bit 2 enables detection; otherwise controls inert.
// - bit 0 switches on the reference voltage buffer.
module scr_system_control
  import scr_pkg::*;
(
  input  wire logic                 mclk,
  input  wire logic                 resetn,
  input  wire logic [scr_pkg::BUS_AW-1:0] addr,
  input  wire logic [7:0]           wdata,
  input  wire logic                 wr,
  input  wire logic                 rd,
  output logic      [7:0]           rdata,
  input  wire logic                 ext_clk,
  input  wire logic                 lv_detect,
  input  wire logic                 stop_mode,
  input  wire logic                 cmp_out,
  output logic                      watchdog_clock_select,
  output logic                      two_wire_pin_select,
  output logic                      capture_ch0_in,
  output logic                      wakeup_irq,
  output logic                      low_voltage_irq,
  output logic                      low_voltage_reset,
  output logic                      reference_buffer_enable
);
  import scr_pkg::*;

  // ==========================================================================
  // registers
  logic [7:0]  options_r;
  logic        wdog_written_r;
  logic [7:0]  wake_ctrl_r;
  logic        wake_flag_r;
  logic        lv_ie_r;
  logic        lv_se_r;
  logic        lv_re_r;
  logic        lv_de_r;
  logic        lv_re_written_r;
  logic        lv_de_written_r;
  logic        ref_buf_r;
  logic        lv_flag_r;
  logic        junk_r;

  logic        sel_opt;
  logic        sel_hi;
  logic        sel_lo;
  logic        sel_wake;
  logic        sel_lv;

  assign sel_opt  = addr == {1'b0, OFS_SYSTEM_OPTIONS};
  assign sel_hi   = addr == {1'b0, OFS_PART_HIGH};
  assign sel_lo   = addr == {1'b0, OFS_PART_LOW};
  assign sel_wake = addr == {1'b0, OFS_WAKEUP_CTRL};
  assign sel_lv   = addr == OFS_LOW_VOLTAGE;

  // ==========================================================================
  // system options
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      options_r      <= RST_SYSTEM_OPTIONS;
      wdog_written_r <= 1'b0;
    end else if (wr && sel_opt) begin
      options_r[BIT_TWO_WIRE] <= wdata[BIT_TWO_WIRE];
      options_r[BIT_CMP_CAP]  <= wdata[BIT_CMP_CAP];
      if (!wdog_written_r) begin
        options_r[BIT_WDOG_CLK] <= wdata[BIT_WDOG_CLK];
        wdog_written_r          <= 1'b1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      watchdog_clock_select <= 1'b0;
      two_wire_pin_select   <= 1'b0;
      capture_ch0_in        <= 1'b0;
    end else begin
      watchdog_clock_select <= options_r[BIT_WDOG_CLK];
      two_wire_pin_select   <= options_r[BIT_TWO_WIRE];
      capture_ch0_in        <= options_r[BIT_CMP_CAP] & cmp_out;
    end
  end

  // ==========================================================================
  // external clock and detect input synchronisers
  logic [1:0] ext_sync_r;
  logic       ext_prev_r;
  logic [1:0] lv_sync_r;
  logic       ext_rise;

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      ext_sync_r <= 2'b00;
      ext_prev_r <= 1'b0;
      lv_sync_r  <= 2'b00;
    end else begin
      ext_sync_r <= {ext_sync_r[0], ext_clk};
      ext_prev_r <= ext_sync_r[1];
      lv_sync_r  <= {lv_sync_r[0], lv_detect};
    end
  end

  // external clock must be below half of mclk to be seen
  assign ext_rise = ext_sync_r[1] & ~ext_prev_r;

  // ==========================================================================
  // 1 kHz tick; free running, so the first timeout may come early
  logic [14:0] tick_cnt_r;
  logic        tick;

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      tick_cnt_r <= 15'h0000;
    end else if (tick_cnt_r == TICK_LAST) begin
      tick_cnt_r <= 15'h0000;
    end else begin
      tick_cnt_r <= tick_cnt_r + 15'h0001;
    end
  end

  assign tick = tick_cnt_r == TICK_LAST;

  // ==========================================================================
  // wakeup timer
  function automatic logic [15:0] wake_limit(input logic [2:0] sel, input logic ext);
    int n;
    n = 1;
    unique case (sel)
      3'h1: n = ext ? WAKE_EXT_1 : WAKE_MS_1;
      3'h2: n = ext ? WAKE_EXT_2 : WAKE_MS_2;
      3'h3: n = ext ? WAKE_EXT_3 : WAKE_MS_3;
      3'h4: n = ext ? WAKE_EXT_4 : WAKE_MS_4;
      3'h5: n = ext ? WAKE_EXT_5 : WAKE_MS_5;
      3'h6: n = ext ? WAKE_EXT_6 : WAKE_MS_6;
      3'h7: n = ext ? WAKE_EXT_7 : WAKE_MS_7;
      3'h0: n = 1;
    endcase
    return 16'(n - 1);
  endfunction

  logic [15:0] wake_cnt_r;
  logic        wake_step;
  logic        wake_hit;
  logic        wake_ext;
  logic [2:0]  wake_sel;

  assign wake_ext  = wake_ctrl_r[BIT_WAKE_CLK];
  assign wake_sel  = wake_ctrl_r[2:0];
  assign wake_step = (wake_sel != 3'h0) && (wake_ext ? ext_rise : tick);
  assign wake_hit  = wake_step && (wake_cnt_r == wake_limit(wake_sel, wake_ext));

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      wake_cnt_r <= 16'h0000;
    end else if (wr && sel_wake) begin
      // reconfiguration restarts the period
      wake_cnt_r <= 16'h0000;
    end else if (wake_hit) begin
      wake_cnt_r <= 16'h0000;
    end else if (wake_step) begin
      wake_cnt_r <= wake_cnt_r + 16'h0001;
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      wake_ctrl_r <= RST_WAKEUP_CTRL;
    end else if (wr && sel_wake) begin
      wake_ctrl_r[BIT_WAKE_CLK] <= wdata[BIT_WAKE_CLK];
      wake_ctrl_r[BIT_WAKE_IE]  <= wdata[BIT_WAKE_IE];
      wake_ctrl_r[2:0]          <= wdata[2:0];
    end
  end

  // set wins over a simultaneous acknowledge
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      wake_flag_r <= 1'b0;
    end else if (wake_hit) begin
      wake_flag_r <= 1'b1;
    end else if (wr && sel_wake && wdata[BIT_WAKE_ACK]) begin
      wake_flag_r <= 1'b0;
    end
  end

  // ==========================================================================
  // low-voltage control
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      lv_ie_r         <= RST_LOW_VOLTAGE[BIT_LV_IE];
      lv_se_r         <= RST_LOW_VOLTAGE[BIT_LV_SE];
      lv_re_r         <= RST_LOW_VOLTAGE[BIT_LV_RE];
      lv_de_r         <= RST_LOW_VOLTAGE[BIT_LV_DE];
      ref_buf_r       <= RST_LOW_VOLTAGE[BIT_REF_BUF];
      lv_re_written_r <= 1'b0;
      lv_de_written_r <= 1'b0;
    end else if (wr && sel_lv) begin
      lv_ie_r   <= wdata[BIT_LV_IE];
      lv_se_r   <= wdata[BIT_LV_SE];
      ref_buf_r <= wdata[BIT_REF_BUF];
      // bit 1 is reserved and dropped; software keeps it 0
      if (!lv_re_written_r) begin
        lv_re_r         <= wdata[BIT_LV_RE];
        lv_re_written_r <= 1'b1;
      end
      if (!lv_de_written_r) begin
        lv_de_r         <= wdata[BIT_LV_DE];
        lv_de_written_r <= 1'b1;
      end
    end
  end

  logic lv_event;

  // in stop mode detection runs only if the stop enable is set
  assign lv_event = lv_sync_r[1] && lv_de_r && (!stop_mode || lv_se_r);

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      lv_flag_r <= 1'b0;
    end else if (lv_event) begin
      lv_flag_r <= 1'b1;
    end else if (wr && sel_lv && wdata[BIT_LV_ACK]) begin
      lv_flag_r <= 1'b0;
    end
  end

  // ==========================================================================
  // outputs
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      wakeup_irq              <= 1'b0;
      low_voltage_irq         <= 1'b0;
      low_voltage_reset       <= 1'b0;
      reference_buffer_enable <= 1'b0;
    end else begin
      wakeup_irq              <= wake_flag_r & wake_ctrl_r[BIT_WAKE_IE];
      low_voltage_irq         <= lv_flag_r & lv_ie_r;
      low_voltage_reset       <= lv_flag_r & lv_re_r & lv_de_r;
      reference_buffer_enable <= ref_buf_r;
    end
  end

  // ==========================================================================
  // read path; reserved high nibble returns a free-running toggle
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      junk_r <= 1'b0;
    end else begin
      junk_r <= ~junk_r;
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      rdata <= 8'h00;
    end else if (rd) begin
      if (sel_opt) begin
        rdata <= {options_r[BIT_WDOG_CLK], 5'h00, options_r[BIT_TWO_WIRE], options_r[BIT_CMP_CAP]};
      end else if (sel_hi) begin
        rdata <= {{4{junk_r}}, PART_NUMBER[11:8]};
      end else if (sel_lo) begin
        rdata <= PART_NUMBER[7:0];
      end else if (sel_wake) begin
        rdata <= {wake_flag_r, 1'b0, wake_ctrl_r[BIT_WAKE_CLK], wake_ctrl_r[BIT_WAKE_IE], 1'b0, wake_sel};
      end else if (sel_lv) begin
        rdata <= {lv_flag_r, 1'b0, lv_ie_r, lv_re_r, lv_se_r, lv_de_r, 1'b0, ref_buf_r};
      end else begin
        rdata <= 8'h00;
      end
    end else begin
      rdata <= 8'h00;
    end
  end

endmodule

// ---- tb/scr_system_control_sva.sv ----
module scr_system_control_sva
  import scr_pkg::*;
(
  input wire logic       mclk,
  input wire logic       resetn,
  input wire logic [4:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr,
  input wire logic       rd,
  input wire logic [7:0] rdata,
  input wire logic       watchdog_clock_select,
  input wire logic       two_wire_pin_select,
  input wire logic       capture_ch0_in,
  input wire logic       wakeup_irq,
  input wire logic       low_voltage_irq,
  input wire logic       low_voltage_reset,
  input wire logic       reference_buffer_enable
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  // ==========================================================
  // helpers
  // every write after the first one must leave the clock source alone
  logic seen_opt_r;
  always_ff @(posedge mclk) begin
    if (!resetn) seen_opt_r <= 1'b0;
    else if (wr && addr == 5'h00) seen_opt_r <= 1'b1;
  end
  sequence s_opt_clr;
    wr && addr == 5'h00 && !wdata[0] ##1 !(wr && addr == 5'h00);
  endsequence
  // ==========================================================
  // assertions
  wake_ack_zero_a: assert property (rd && addr == 5'h0C |=> !rdata[6])
    else $error("wakeup ack bit read nonzero");
  lv_ack_zero_a: assert property (rd && addr == 5'h10 |=> !rdata[6] && !rdata[1])
    else $error("low-voltage ack or reserved bit read nonzero");
  part_low_a: assert property (rd && addr == 5'h08 |=> rdata == PART_NUMBER[7:0])
    else $error("part number low byte wrong");
  part_high_a: assert property (rd && addr == 5'h04 |=> rdata[3:0] == PART_NUMBER[11:8])
    else $error("part number high nibble wrong");
  wdog_once_a: assert property (wr && addr == 5'h00 && seen_opt_r |=> ##1 $stable(watchdog_clock_select))
    else $error("watchdog clock select changed after second write");
  pin_route_a: assert property (wr && addr == 5'h00 |=> ##1 two_wire_pin_select == $past(wdata[1], 2))
    else $error("two-wire pin select does not follow write");
  ref_buf_a: assert property (wr && addr == 5'h10 |=> ##1 reference_buffer_enable == $past(wdata[0], 2))
    else $error("reference buffer enable does not follow write");
  cap_off_a: assert property (s_opt_clr |=> !capture_ch0_in)
    else $error("comparator reaches capture while disconnected");
  reset_quiet_a: assert property (disable iff (1'b0) !resetn |=> !wakeup_irq && !low_voltage_irq
    && !low_voltage_reset && !reference_buffer_enable && !capture_ch0_in)
    else $error("outputs active after reset edge");
endmodule
bind scr_system_control scr_system_control_sva i_sva (.mclk, .resetn, .addr, .wdata, .wr, .rd, .rdata,
  .watchdog_clock_select, .two_wire_pin_select, .capture_ch0_in, .wakeup_irq, .low_voltage_irq,
  .low_voltage_reset, .reference_buffer_enable);

// ---- tb/tb_scr_system_control.sv ----
module tb_scr_system_control;
  timeunit 1ns;
  timeprecision 1ps;
  import scr_pkg::*;
  logic       mclk = 0, resetn = 0, wr = 0, rd = 0, ext_run = 0;
  logic       ext_clk = 0, lv_detect = 0, stop_mode = 0, cmp_out = 0;
  logic [4:0] addr = '0;
  logic [7:0] wdata = '0, rdata;
  logic       watchdog_clock_select, two_wire_pin_select, capture_ch0_in, wakeup_irq;
  logic       low_voltage_irq, low_voltage_reset, reference_buffer_enable;
  int         n_fail = 0, check_count = 0, edges = 0, i;
  always #20 mclk = ~mclk;
  // external clock well below half the bus rate, phase unrelated
  always #83 if (ext_run) ext_clk = ~ext_clk;
  always @(posedge ext_clk) edges++;
  scr_system_control i_dut (.mclk, .resetn, .addr, .wdata, .wr, .rd, .rdata, .ext_clk, .lv_detect,
    .stop_mode, .cmp_out, .watchdog_clock_select, .two_wire_pin_select, .capture_ch0_in, .wakeup_irq,
    .low_voltage_irq, .low_voltage_reset, .reference_buffer_enable);
  // ==========================================================
  // tasks
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    check_count++;
    if (s !== e) begin
      n_fail++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic wr_reg(input logic [4:0] a, input logic [7:0] d);
    @(posedge mclk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge mclk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [4:0] a, input logic [7:0] e, input logic [7:0] m = 8'hFF);
    @(posedge mclk);
    rd <= 1'b1;
    addr <= a;
    @(posedge mclk);
    rd <= 1'b0;
    #1;
    chk(rdata & m, e & m);
  endtask
  // bits: watchdog, pins, capture, wake irq, lv irq, lv reset, ref buffer
  task automatic outs(input logic [7:0] e);
    repeat (2) @(posedge mclk);
    #1;
    chk({1'b0, watchdog_clock_select, two_wire_pin_select, capture_ch0_in, wakeup_irq,
         low_voltage_irq, low_voltage_reset, reference_buffer_enable}, e);
  endtask
  task automatic lv_pulse(input int n);
    @(posedge mclk);
    lv_detect <= 1'b1;
    repeat (n) @(posedge mclk);
    lv_detect <= 1'b0;
  endtask
  task automatic end_sim();
    if (n_fail == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // ==========================================================
  // main sequence
  initial begin
    repeat (12) @(posedge mclk);
    resetn <= 1'b1;
    outs(8'h00);
    rd_reg(5'h00, 8'h00);
    rd_reg(5'h04, {4'h0, PART_NUMBER[11:8]}, 8'h0F);
    rd_reg(5'h08, PART_NUMBER[7:0]);
    rd_reg(5'h0C, 8'h00);
    rd_reg(5'h14, 8'h00);
    cmp_out <= 1'b1;
    wr_reg(5'h00, 8'h83);
    wr_reg(5'h14, 8'hFF);
    rd_reg(5'h00, 8'h83);
    outs(8'h70);
    wr_reg(5'h00, 8'h00);
    rd_reg(5'h00, 8'h80);
    outs(8'h40);
    lv_pulse(6);
    rd_reg(5'h10, 8'h00);
    wr_reg(5'h10, 8'h3D);
    rd_reg(5'h10, 8'h3D);
    outs(8'h41);
    lv_pulse(6);
    rd_reg(5'h10, 8'hBD);
    outs(8'h47);
    wr_reg(5'h10, 8'h40);
    rd_reg(5'h10, 8'h14);
    outs(8'h40);
    wr_reg(5'h10, 8'h20);
    stop_mode <= 1'b1;
    lv_pulse(8);
    rd_reg(5'h10, 8'h34);
    stop_mode <= 1'b0;
    lv_pulse(8);
    rd_reg(5'h10, 8'hB4);
    outs(8'h46);
    ext_run = 1'b1;
    wr_reg(5'h0C, 8'h31);
    edges = 0;
    // look 1 ns after the edge so the registered interrupt has settled
    for (i = 0; i < 3000 && wakeup_irq !== 1'b1; i++) begin
      @(posedge mclk);
      #1;
    end
    if (wakeup_irq !== 1'b1) begin
      n_fail++;
      end_sim();
    end
    chk(8'(edges >= 254 && edges <= 258), 8'h01);
    rd_reg(5'h0C, 8'hB1);
    wr_reg(5'h0C, 8'h71);
    rd_reg(5'h0C, 8'h31);
    outs(8'h46);
    wr_reg(5'h0C, 8'h30);
    repeat (1200) @(posedge mclk);
    rd_reg(5'h0C, 8'h30);
    wr_reg(5'h0C, 8'h21);
    repeat (1200) @(posedge mclk);
    rd_reg(5'h0C, 8'hA1);
    outs(8'h46);
    end_sim();
  end
endmodule
